// ===== src/gpio_mux_map.vh
`ifndef GPIO_MUX_MAP_VH
`define GPIO_MUX_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_MUX_SEL 12'h000
`define OFS_OUT_VAL 12'h004
`define OFS_DIR 12'h008
`define OFS_GENERAL_SIGNAL_CONFIG_REG 12'h00c
`define OFS_CTRL 12'h010
`define OFS_WAKE_EN 12'h014
`define OFS_PIN_LVL 12'h018
`define OFS_EVT_STAT 12'h01c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define GENERAL_SIGNAL_CONFIG_REG_REQ_A 0
`define GENERAL_SIGNAL_CONFIG_REG_GNT_A 1
`define GENERAL_SIGNAL_CONFIG_REG_SERIAL_INTERRUPT_LINE 2
`define GENERAL_SIGNAL_CONFIG_REG_RTC_IRQ 3
`define CTRL_FLOPPY_EN 0
`define SPEAKER_OUT_SEL_BIT 1
`define PIN_REQ_A 2
`define PIN_GNT_A 3
`define PIN_RTC_IRQ 6
`define PIN_SERIAL_INTERRUPT_LINE 7
`define PIN_SPEAKER_OUT 14

// ----------------------------------------
// Pin masks and reset values
// ----------------------------------------
`define MUX_MASK 31'h7fffbd33
`define MUX_SEL_RST 31'h7fffbd33
`define WAKE_MASK 31'h01161e13
`define FUNC_WAKE_MASK 31'h01001c01
`define SCI_MASK 31'h00160213
`define FUNC_IDLE 31'h17e91901
`define RESUME_PINS 31'h01161e53
`define GENERAL_SIGNAL_CONFIG_REG_RST 4'h0
`define CTRL_RST 1'h0
`define SYNC_SETTLE 2'h3

`endif

// ===== src/gpio_sync_bank.v
`timescale 1ns/100ps
// ----------------------------------------
// Two-flop synchroniser, one per pin
// ----------------------------------------
module gpio_sync_bank #(
	parameter WIDTH = 31
) (
	input wire clk_sys, // system clock
	input wire sys_rst, // async reset, active high
	input wire [WIDTH-1:0] async_in, // raw pin levels
	output wire [WIDTH-1:0] sync_out // synchronised levels
);
	genvar g;
	generate
		for (g = 0; g < WIDTH; g = g + 1)
		begin : bit_sync
			reg meta_q;
			reg stable_q;
			always @(posedge clk_sys or posedge sys_rst)
			begin
				if (sys_rst)
				begin
					meta_q <= 1'b0;
					stable_q <= 1'b0;
				end
				else
				begin
					meta_q <= async_in[g];
					stable_q <= meta_q;
				end
			end
			assign sync_out[g] = stable_q;
		end
	endgenerate
endmodule

// ===== src/gpio_event_latch.v
`timescale 1ns/100ps
// ----------------------------------------
// Sticky event bits, write one to clear
// ----------------------------------------
module gpio_event_latch #(
	parameter WIDTH = 31
) (
	input wire clk_sys, // system clock
	input wire rst, // async reset, active high
	input wire [WIDTH-1:0] evt_set, // one-cycle event per bit
	input wire [WIDTH-1:0] evt_clr, // one-cycle clear per bit
	output wire [WIDTH-1:0] evt_stat // sticky status
);
	genvar g;
	generate
		for (g = 0; g < WIDTH; g = g + 1)
		begin : bit_latch
			reg stat_q;
			// A set in the clearing cycle wins so no event is lost
			always @(posedge clk_sys or posedge rst)
			begin
				if (rst)
					stat_q <= 1'b0;
				else if (evt_set[g])
					stat_q <= 1'b1;
				else if (evt_clr[g])
					stat_q <= 1'b0;
			end
			assign evt_stat[g] = stat_q;
		end
	endgenerate
endmodule

// ===== src/gpio_mux_top.v
// Functional notes
// - There are 31 general-purpose pins, twelve in the resume domain and the rest in the core.
// - Resume-domain settings and output, direction and select registers use only the resume reset.
// - Muxed pins come out of reset in their dedicated function and turn general only on select 0.
// - A general-purpose pin is input or output as its direction bit says.
// - Request A, grant A, serial interrupt and clock interrupt pins default to general use.
// - When either select register picks a dedicated function the direction bit is ignored.
// - Pin 14 is speaker on select bit 1, else floppy monitor input if enabled, else general.
// - Pins 0, 1, 4, 9, 10, 11, 12, 17, 18, 20 and 24 can wake the system.
// - Pins 0, 1, 4, 9, 17, 18 and 20 raise control and management events and resume events.
// - Pins 0, 10, 11, 12 and 24 wake the system only in their dedicated function.
// - Pin 6 never wakes the system although it sits in the resume domain.
// - After reset the active-low functions idle high, lid input and speaker idle low.
`timescale 1ns/100ps
`include "gpio_mux_map.vh"

module gpio_mux_top #(
	parameter NPINS = 31
) (
	input wire clk_sys, // 200 MHz system clock
	input wire sys_rst, // main bus reset, async, active high
	input wire resume_domain_reset_n, // resume reset, async, active low
	input wire hsel, // AHB slave select
	input wire [31:0] haddr, // AHB address
	input wire [1:0] htrans, // AHB transfer type
	input wire hwrite, // AHB write
	input wire [2:0] hsize, // AHB size
	input wire [31:0] hwdata, // AHB write data
	input wire hready, // AHB bus ready
	output reg [31:0] hrdata, // AHB read data
	output reg hreadyout, // AHB slave ready
	output reg hresp, // AHB response, always OKAY
	input wire [NPINS-1:0] pin_in, // pin levels from the pads
	output wire [NPINS-1:0] pin_out, // pin output values
	output wire [NPINS-1:0] pin_oe, // pin output enables, high drives
	input wire [NPINS-1:0] func_out, // dedicated function output values
	input wire [NPINS-1:0] func_oe, // dedicated function output enables
	output reg [NPINS-1:0] func_in, // pin levels to dedicated functions
	output reg floppy_activity, // floppy monitor level from pin 14
	output reg wake_req, // wake request level
	output reg sci_req // control and management event request level
);
	// ----------------------------------------
	// Resets
	// ----------------------------------------
	wire resume_rst;
	assign resume_rst = ~resume_domain_reset_n;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [NPINS-1:0] mux_sel_q; // muxed_pin_select_reg
	reg [NPINS-1:0] out_val_q; // pin_output_value_reg
	reg [NPINS-1:0] dir_q;
	reg [NPINS-1:0] wake_en_q;
	reg [3:0] general_signal_config_reg_q; // general_signal_config_reg
	reg floppy_en_q; // floppy_monitor_enable
	reg [NPINS-1:0] lvl_q;
	reg wr_pend_q;
	reg [11:0] wr_addr_q;

	wire [NPINS-1:0] pin_sync;
	wire [NPINS-1:0] evt_stat;
	reg [NPINS-1:0] evt_set;
	reg [NPINS-1:0] evt_clr;
	reg [NPINS-1:0] dedicated;
	reg [31:0] rd_d;
	wire addr_phase;
	wire [11:0] a_ofs;
	reg [NPINS-1:0] drv_out_d;
	reg [NPINS-1:0] drv_oe_d;
	reg [1:0] settle_q;
	localparam [NPINS-1:0] RESUME_MAP = `RESUME_PINS;
	localparam [NPINS-1:0] IDLE_MAP = `FUNC_IDLE;
	genvar g;

	// ----------------------------------------
	// Pin input synchronisers
	// ----------------------------------------
	gpio_sync_bank #(
		.WIDTH(NPINS)
	) u_sync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.async_in(pin_in),
		.sync_out(pin_sync)
	);

	// ----------------------------------------
	// AHB slave, zero wait states
	// ----------------------------------------
	assign addr_phase = hsel & htrans[1] & hready;
	assign a_ofs = haddr[11:0];

	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 12'h000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h00000000;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (hready)
			begin
				wr_pend_q <= addr_phase & hwrite;
				wr_addr_q <= a_ofs;
			end
			// Read data is fetched in the address phase so it stands from a flop
			if (addr_phase & ~hwrite)
				hrdata <= rd_d;
		end
	end

	always @*
	begin
		rd_d = 32'h00000000;
		if (a_ofs == `OFS_MUX_SEL)
			rd_d = {1'b0, mux_sel_q};
		else if (a_ofs == `OFS_OUT_VAL)
			rd_d = {1'b0, out_val_q};
		else if (a_ofs == `OFS_DIR)
			rd_d = {1'b0, dir_q};
		else if (a_ofs == `OFS_GENERAL_SIGNAL_CONFIG_REG)
			rd_d = {28'h0000000, general_signal_config_reg_q};
		else if (a_ofs == `OFS_CTRL)
			rd_d = {31'h00000000, floppy_en_q};
		else if (a_ofs == `OFS_WAKE_EN)
			rd_d = {1'b0, wake_en_q};
		else if (a_ofs == `OFS_PIN_LVL)
			rd_d = {1'b0, lvl_q};
		else if (a_ofs == `OFS_EVT_STAT)
			rd_d = {1'b0, evt_stat};
	end

	// ----------------------------------------
	// Resume-domain registers
	// ----------------------------------------
	// Only the resume reset touches these so they survive sleep
	always @(posedge clk_sys or posedge resume_rst)
	begin
		if (resume_rst)
		begin
			mux_sel_q <= `MUX_SEL_RST;
			out_val_q <= {NPINS{1'b0}};
			dir_q <= {NPINS{1'b0}};
			wake_en_q <= {NPINS{1'b0}};
		end
		else if (wr_pend_q)
		begin
			if (wr_addr_q == `OFS_MUX_SEL)
				mux_sel_q <= hwdata[NPINS-1:0] & `MUX_MASK;
			else if (wr_addr_q == `OFS_OUT_VAL)
				out_val_q <= hwdata[NPINS-1:0];
			else if (wr_addr_q == `OFS_DIR)
				dir_q <= hwdata[NPINS-1:0];
			else if (wr_addr_q == `OFS_WAKE_EN)
				wake_en_q <= hwdata[NPINS-1:0] & `WAKE_MASK;
		end
	end

	// ----------------------------------------
	// Core-domain registers
	// ----------------------------------------
	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			general_signal_config_reg_q <= `GENERAL_SIGNAL_CONFIG_REG_RST;
			floppy_en_q <= `CTRL_RST;
		end
		else if (wr_pend_q)
		begin
			if (wr_addr_q == `OFS_GENERAL_SIGNAL_CONFIG_REG)
				general_signal_config_reg_q <= hwdata[3:0];
			else if (wr_addr_q == `OFS_CTRL)
				floppy_en_q <= hwdata[`CTRL_FLOPPY_EN];
		end
	end

	// ----------------------------------------
	// Function selection
	// ----------------------------------------
	// Pin 14 follows select bit 1 here; its floppy monitor choice is resolved below
	always @*
	begin
		dedicated = mux_sel_q & `MUX_MASK;
		dedicated[`SPEAKER_OUT_SEL_BIT] = 1'b0;
		dedicated[`PIN_SPEAKER_OUT] = mux_sel_q[`SPEAKER_OUT_SEL_BIT];
		dedicated[`PIN_REQ_A] = general_signal_config_reg_q[`GENERAL_SIGNAL_CONFIG_REG_REQ_A];
		dedicated[`PIN_GNT_A] = general_signal_config_reg_q[`GENERAL_SIGNAL_CONFIG_REG_GNT_A];
		dedicated[`PIN_SERIAL_INTERRUPT_LINE] = general_signal_config_reg_q[`GENERAL_SIGNAL_CONFIG_REG_SERIAL_INTERRUPT_LINE];
		dedicated[`PIN_RTC_IRQ] = general_signal_config_reg_q[`GENERAL_SIGNAL_CONFIG_REG_RTC_IRQ];
	end

	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------
	// Direction bits only matter for pins not in a dedicated function
	always @*
	begin
		drv_out_d = (dedicated & func_out) | (~dedicated & out_val_q);
		drv_oe_d = (dedicated & func_oe) | (~dedicated & dir_q);
		if (~mux_sel_q[`SPEAKER_OUT_SEL_BIT] & floppy_en_q)
		begin
			drv_oe_d[`PIN_SPEAKER_OUT] = 1'b0;
			drv_out_d[`PIN_SPEAKER_OUT] = 1'b0;
		end
	end

	// Resume pins keep driving through a main reset so sleeping parts see no
	// glitch; core pins release the pad and load their idle value while the main reset is high
	generate
		for (g = 0; g < NPINS; g = g + 1)
		begin : pin_drv
			reg out_q;
			reg oe_q;
			if (RESUME_MAP[g])
			begin : resume_pin
				always @(posedge clk_sys or posedge resume_rst)
				begin
					if (resume_rst)
					begin
						out_q <= IDLE_MAP[g];
						oe_q <= 1'b0;
					end
					else
					begin
						out_q <= drv_out_d[g];
						oe_q <= drv_oe_d[g];
					end
				end
			end
			else
			begin : core_pin
				always @(posedge clk_sys or posedge sys_rst)
				begin
					if (sys_rst)
					begin
						out_q <= IDLE_MAP[g];
						oe_q <= 1'b0;
					end
					else
					begin
						out_q <= drv_out_d[g];
						oe_q <= drv_oe_d[g];
					end
				end
			end
			assign pin_out[g] = out_q;
			assign pin_oe[g] = oe_q;
		end
	endgenerate

	// Function inputs idle at their inactive level while in reset
	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			func_in <= `FUNC_IDLE;
			floppy_activity <= 1'b0;
		end
		else
		begin
			func_in <= (dedicated & pin_sync) | (~dedicated & `FUNC_IDLE);
			floppy_activity <= 1'b0;
			if (~mux_sel_q[`SPEAKER_OUT_SEL_BIT] & floppy_en_q)
				floppy_activity <= pin_sync[`PIN_SPEAKER_OUT];
		end
	end

	// ----------------------------------------
	// Level capture and wake events
	// ----------------------------------------
	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			lvl_q <= {NPINS{1'b0}};
		else
			lvl_q <= pin_sync;
	end

	// A main reset clears the synchronisers; edges seen before they refill
	// would be false wake events
	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			settle_q <= 2'h0;
		else if (settle_q != `SYNC_SETTLE)
			settle_q <= settle_q + 2'h1;
	end

	// Any level change on a capable pin is an event; pin 6 is never in the mask
	always @*
	begin
		evt_set = (pin_sync ^ lvl_q) & `WAKE_MASK;
		evt_set = evt_set & (~`FUNC_WAKE_MASK | dedicated);
		if (settle_q != `SYNC_SETTLE)
			evt_set = {NPINS{1'b0}};
		evt_clr = {NPINS{1'b0}};
		if (wr_pend_q && wr_addr_q == `OFS_EVT_STAT)
			evt_clr = hwdata[NPINS-1:0];
	end

	gpio_event_latch #(
		.WIDTH(NPINS)
	) u_evt (
		.clk_sys(clk_sys),
		.rst(resume_rst),
		.evt_set(evt_set),
		.evt_clr(evt_clr),
		.evt_stat(evt_stat)
	);

	always @(posedge clk_sys or posedge resume_rst)
	begin
		if (resume_rst)
		begin
			wake_req <= 1'b0;
			sci_req <= 1'b0;
		end
		else
		begin
			wake_req <= |(evt_stat & wake_en_q & `WAKE_MASK);
			sci_req <= |(evt_stat & wake_en_q & `SCI_MASK);
		end
	end

endmodule

// ===== dv/gpio_mux_monitor.sv
`timescale 1ns/100ps
`include "gpio_mux_map.vh"
module gpio_mux_monitor #(
	parameter NPINS = 31
) (
	input wire clk_sys, // clock
	input wire sys_rst, // main reset
	input wire resume_domain_reset_n, // resume reset
	input wire hsel, // select
	input wire [31:0] haddr, // address
	input wire [1:0] htrans, // transfer
	input wire hwrite, // write
	input wire [31:0] hwdata, // wdata
	input wire hready, // ready in
	input wire [31:0] hrdata, // rdata
	input wire hreadyout, // ready out
	input wire hresp, // response
	input wire [NPINS-1:0] pin_out, // pad value
	input wire [NPINS-1:0] pin_oe, // pad enable
	input wire [NPINS-1:0] func_out, // function value
	input wire [NPINS-1:0] func_oe, // function enable
	input wire [NPINS-1:0] func_in, // to functions
	input wire floppy_activity, // floppy level
	input wire wake_req, // wake
	input wire sci_req // event
);
	localparam [30:0] SCI_PINS = 31'h00160213;
	reg [30:0] mux_q, out_q, dir_q, wen_q;
	reg [3:0] gs_q;
	reg fe_q, rdy_q, wr_q, rd_q;
	reg [11:0] a_q;
	wire [30:0] ded = (mux_q & ~31'h2) |
		{16'h0, mux_q[1], 6'h0, gs_q[2], gs_q[3], 2'h0, gs_q[1:0], 2'h0};
	wire fl = fe_q & ~mux_q[1];
	wire [30:0] e_oe = ((ded & func_oe) | (~ded & dir_q)) & ~({30'h0, fl} << 14);
	wire [30:0] e_out = (ded & func_out) | (~ded & out_q);
	// ----------------
	// Register shadow
	// ----------------
	always @(posedge clk_sys or negedge resume_domain_reset_n)
	begin
		if (!resume_domain_reset_n)
		begin
			mux_q <= `MUX_SEL_RST;
			out_q <= 31'h0;
			dir_q <= 31'h0;
			wen_q <= 31'h0;
		end
		else if (wr_q)
		begin
			case (a_q)
			`OFS_MUX_SEL: mux_q <= hwdata[30:0] & `MUX_MASK;
			`OFS_OUT_VAL: out_q <= hwdata[30:0];
			`OFS_DIR: dir_q <= hwdata[30:0];
			`OFS_WAKE_EN: wen_q <= hwdata[30:0] & `WAKE_MASK;
			default: ;
			endcase
		end
	end
	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			gs_q <= `GENERAL_SIGNAL_CONFIG_REG_RST;
			fe_q <= `CTRL_RST;
			rdy_q <= 1'b0;
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			a_q <= 12'h0;
		end
		else
		begin
			rdy_q <= 1'b1;
			wr_q <= hsel & htrans[1] & hready & hwrite;
			rd_q <= hsel & htrans[1] & hready & ~hwrite;
			a_q <= haddr[11:0];
			if (wr_q && a_q == `OFS_GENERAL_SIGNAL_CONFIG_REG)
				gs_q <= hwdata[3:0];
			if (wr_q && a_q == `OFS_CTRL)
				fe_q <= hwdata[0];
		end
	end
	// ----------------
	// Properties
	// ----------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst || !resume_domain_reset_n);
	AST_BUS: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	AST_OE_SEL: assert property (rdy_q |-> pin_oe == $past(e_oe))
		else $error("pad enable does not follow selection");
	AST_OUT_SEL: assert property (rdy_q |-> ((pin_out ^ $past(e_out)) & pin_oe) == 31'h0)
		else $error("pad value does not follow selection");
	AST_IDLE: assert property (disable iff (!resume_domain_reset_n)
		sys_rst |-> func_in == `FUNC_IDLE && (pin_oe & ~`RESUME_PINS) == 31'h0)
		else $error("idle levels wrong in reset");
	AST_FLOPPY: assert property (floppy_activity |-> $past(fl))
		else $error("floppy level outside floppy mode");
	AST_SCI_WAKE: assert property (sci_req |-> wake_req)
		else $error("event request without wake request");
	AST_WAKE_OFF: assert property (wen_q == 31'h0 |=> !wake_req)
		else $error("wake request with no pin enabled");
	AST_SCI_OFF: assert property ((wen_q & SCI_PINS) == 31'h0 |=> !sci_req)
		else $error("event request with no event pin enabled");
	AST_RD_REG: assert property (rd_q && a_q <= `OFS_DIR |-> hrdata ==
		{1'b0, a_q == `OFS_MUX_SEL ? mux_q : a_q == `OFS_OUT_VAL ? out_q : dir_q})
		else $error("register read back wrong");
	AST_UNMAP: assert property (rd_q && a_q == 12'h020 |-> hrdata == 32'h0)
		else $error("unmapped read not zero");
	cover property (floppy_activity);
	cover property (wake_req && sci_req);
	cover property (rd_q && a_q == 12'h020);
endmodule
bind gpio_mux_top gpio_mux_monitor #(.NPINS(NPINS)) u_mon (.*);

// ===== dv/gpio_pad_model.sv
`timescale 1ns/100ps
module gpio_pad_model (
	input wire [30:0] pin_out, // pad drive value
	input wire [30:0] pin_oe, // pad drive enable
	input wire [30:0] ext_val, // far-side level
	output wire [30:0] pad // resolved level
);
	// Far-side switches rest high, like the active-low alarm and wake lines
	assign pad = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule

// ===== dv/gpio_mux_and_wake_select_bench.sv
`timescale 1ns/100ps
`include "gpio_mux_map.vh"
module gpio_mux_and_wake_select_bench;
	localparam [30:0] WAKE_PINS = 31'h01161e13;
	localparam [30:0] FUNC_ONLY = 31'h01001c01;
	localparam [30:0] SCI_PINS = 31'h00160213;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic resume_domain_reset_n = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [30:0] func_out = 31'h0;
	logic [30:0] func_oe = 31'h0;
	logic [30:0] ext = 31'h7fffffff;
	logic [31:0] rd, m, ov, dr, gw, cw;
	logic e;
	wire [31:0] hrdata;
	wire hreadyout, hresp, floppy_activity, wake_req, sci_req;
	wire [30:0] pin_in, pin_out, pin_oe, func_in;
	int miscompares = 0;
	int checks = 0;
	int unsigned r;
	always #2.5 clk_sys = ~clk_sys;
	gpio_mux_top dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.resume_domain_reset_n(resume_domain_reset_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .func_out(func_out), .func_oe(func_oe),
		.func_in(func_in), .floppy_activity(floppy_activity), .wake_req(wake_req),
		.sci_req(sci_req));
	gpio_pad_model u_pad (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext), .pad(pin_in));
	// ----------------
	// Helpers
	// ----------------
	function automatic logic wake_exp(input int p, input int mode);
		return WAKE_PINS[p] && (!FUNC_ONLY[p] || mode != 0);
	endfunction
	function automatic logic [30:0] rnd();
		logic [31:0] v;
		v = $urandom;
		return v[30:0];
	endfunction
	task automatic end_sim();
		if (miscompares == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		checks++;
		if (g !== x)
		begin
			miscompares++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, x);
		end
	endtask
	task automatic hold();
		int k;
		k = 0;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1)
		begin
			k++;
			if (k > 64)
			begin
				miscompares++;
				end_sim();
			end
			@(posedge clk_sys);
		end
	endtask
	task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {20'h0, a};
		hold();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		hold();
		rd = hrdata;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] x);
		ahb(1'b0, a, 32'h0);
		chk(rd, x);
	endtask
	// Expected pad drive worked out from the selection rules
	task automatic pins_chk(input logic [30:0] ms, input logic [30:0] ovl,
		input logic [30:0] drl, input logic [3:0] gs, input logic fe);
		logic [30:0] d, eo, ev, pad;
		logic fl;
		d = ms & `MUX_MASK;
		d[1] = 1'b0;
		d[14] = ms[1];
		d[2] = gs[0];
		d[3] = gs[1];
		d[7] = gs[2];
		d[6] = gs[3];
		fl = fe & ~ms[1];
		eo = (d & func_oe) | (~d & drl);
		eo[14] = eo[14] & ~fl;
		ev = (d & func_out) | (~d & ovl);
		pad = (eo & ev) | (~eo & ext);
		@(negedge clk_sys);
		chk({1'b0, pin_oe}, {1'b0, eo});
		chk({1'b0, pin_out & eo}, {1'b0, ev & eo});
		chk({1'b0, func_in}, {1'b0, (d & pad) | (~d & `FUNC_IDLE)});
		chk({31'h0, floppy_activity}, {31'h0, fl & pad[14]});
		@(posedge clk_sys);
	endtask
	// ----------------
	// Main sequence
	// ----------------
	initial
	begin
		r = $urandom(32'h3401);
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'b0;
		resume_domain_reset_n <= 1'b1;
		@(posedge clk_sys);
		rchk(`OFS_MUX_SEL, {1'b0, `MUX_MASK});
		rchk(`OFS_GENERAL_SIGNAL_CONFIG_REG, 32'h0);
		rchk(12'h020, 32'h0);
		for (int i = 0; i < 10; i++)
		begin
			m = (i == 0) ? 32'h0 : $urandom;
			ov = $urandom;
			dr = $urandom;
			gw = $urandom;
			cw = (i == 0) ? 32'h1 : $urandom;
			ahb(1'b1, `OFS_MUX_SEL, m);
			ahb(1'b1, `OFS_OUT_VAL, ov);
			ahb(1'b1, `OFS_DIR, dr);
			ahb(1'b1, `OFS_GENERAL_SIGNAL_CONFIG_REG, gw);
			ahb(1'b1, `OFS_CTRL, cw);
			func_out <= rnd();
			func_oe <= rnd();
			ext <= (i == 0) ? 31'h7fffffff : rnd();
			rchk(`OFS_MUX_SEL, {1'b0, m[30:0] & `MUX_MASK});
			repeat (4) @(posedge clk_sys);
			pins_chk(m[30:0], ov[30:0], dr[30:0], gw[3:0], cw[0]);
		end
		m = $urandom;
		ahb(1'b1, `OFS_DIR, m);
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		rchk(`OFS_DIR, {1'b0, m[30:0]});
		rchk(`OFS_GENERAL_SIGNAL_CONFIG_REG, 32'h0);
		func_oe <= 31'h0;
		ahb(1'b1, `OFS_DIR, 32'h0);
		ahb(1'b1, `OFS_MUX_SEL, 32'h0);
		ext <= rnd();
		repeat (6) @(posedge clk_sys);
		rchk(`OFS_PIN_LVL, {1'b0, ext});
		ext <= 31'h7fffffff;
		ahb(1'b1, `OFS_WAKE_EN, 32'hffffffff);
		for (int mode = 0; mode < 2; mode++)
		begin
			ahb(1'b1, `OFS_MUX_SEL, (mode != 0) ? 32'hffffffff : 32'h0);
			repeat (8) @(posedge clk_sys);
			ahb(1'b1, `OFS_EVT_STAT, 32'hffffffff);
			for (int p = 0; p < 31; p++)
			begin
				ext[p] <= ~ext[p];
				repeat (8) @(posedge clk_sys);
				e = wake_exp(p, mode);
				rchk(`OFS_EVT_STAT, e ? (32'h1 << p) : 32'h0);
				chk({31'h0, wake_req}, {31'h0, e});
				chk({31'h0, sci_req}, {31'h0, e & SCI_PINS[p]});
				ahb(1'b1, `OFS_EVT_STAT, 32'hffffffff);
			end
		end
		end_sim();
	end
endmodule
